/* cpu_model_pkg.sv */
// types used by the core state block; the register memory does not use them
package cpu_model_pkg;

	// accumulator operation select, one-hot
	typedef enum logic [3:0]
	{
		ACC_HOLD = 4'b0001,
		ACC_CLR = 4'b0010,
		ACC_MAC = 4'b0100,
		ACC_LOAD = 4'b1000
	} accOp_t;

	// program-space visibility access sequencer
	typedef enum logic [1:0]
	{
		PSV_IDLE = 2'b01,
		PSV_WAIT = 2'b10
	} psvState_t;

endpackage

/* cpu_model_regs.svh */
// offsets, field positions, reset values and counts of the programmer-visible core state
`ifndef CPU_MODEL_REGS_SVH
`define CPU_MODEL_REGS_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define PC_W 23
`define WORD_W 16
`define ACC_W 40
`define MUL_W 17
`define INSTR_W 24
`define PAGE_W 8

// ----------------------------------------------------------------------
// reset values, fixed indices and step sizes
// ----------------------------------------------------------------------
`define SP_RESET 16'h0800
`define SP_IDX 4'hf
`define SHADOW_TOP 4'h3
`define STATUS_RESET 16'h0000
`define PAGE_RESET 8'h00
`define SP_STEP 16'h0002
`define PC_STEP 23'h000002

// ----------------------------------------------------------------------
// status word fields
// ----------------------------------------------------------------------
`define ST_C 0
`define ST_Z 1
`define ST_OVF 2
`define ST_N 3
`define ST_REPEAT 4
`define ST_LEVEL_LO 5
`define ST_LEVEL_HI 7
`define ST_DIGIT 8
`define ST_LOOP 9
`define ST_SAB 10
`define ST_OAB 11
`define ST_SB 12
`define ST_SA 13
`define ST_OB 14
`define ST_OA 15
`define ST_SHADOW_MASK 16'h010f

// ----------------------------------------------------------------------
// data space split and exception structure
// ----------------------------------------------------------------------
`define PSV_BIT 15
`define Y_BASE 16'h0800
`define N_TRAPS 8
`define N_IRQS 54
`define N_VECTORS 62
`define TRAP_PRIO_BASE 4'h8

`endif

/* cpu_prog_model.sv */
// programmer-visible state of the 16-bit signal-processing core
`include "cpu_model_regs.svh"

// Operation
// - pc is 23 bits, bit 0 clear
// - sixteen 16-bit general working registers
// - register fifteen is hardware-adjusted stack pointer
// - stack pointer bit 0 reads zero
// - stack pointer resets to 0x0800
// - 64K data split X/Y, fixed boundary
// - upper data half maps through page register
// - window access costs a cycle, low 16 bits
// - table access reaches all 24 instruction bits
// - bit reversal on X destination only
// - read, register read, write, fetch per cycle
// - shifter: 15 right or 16 left
// - two saturating 40-bit accumulators, 17x17 multiplier
// - one-stage prefetch, no deeper pipeline
// - 62 vectors: 8 traps, 54 interrupts
// - interrupt priority 1..7, ties by index
// - traps fixed at priority 8..15
// - shadow push/pop registers 0-3 and flags
// - loop start pushes loop regs, end restores
// - byte op touches only low byte
// - exception stacks status low byte with pc top
// - status word layout, low and high bytes
module cpu_prog_model #(
	parameter int BR_BITS = 4
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic pcLoad,
	input wire logic [22:0] pcTarget,
	input wire logic pcHold,
	input wire logic [23:0] progRdData,
	output logic [23:0] progAddr,
	output logic [23:0] instrQ,
	output logic wrEn,
	input wire logic [3:0] wrSel,
	input wire logic [15:0] wrData,
	input wire logic [1:0] wrByteEn,
	input wire logic wrByteOp,
	input wire logic [3:0] rdSel,
	output logic [15:0] rdData,
	input wire logic spPush,
	input wire logic spPop,
	input wire logic shadowPush,
	input wire logic shadowPop,
	input wire logic statusWrEn,
	input wire logic [15:0] statusWrData,
	output logic [15:0] statusWord,
	input wire logic psvWrEn,
	input wire logic [7:0] psvWrData,
	input wire logic tblPageWrEn,
	input wire logic [7:0] tblPageWrData,
	input wire logic loopStart,
	input wire logic loopEnd,
	input wire logic [22:0] loopStartAddr,
	input wire logic [22:0] loopEndAddr,
	input wire logic [13:0] loopCountIn,
	output logic [13:0] loopCount,
	input wire logic dataRd,
	input wire logic [15:0] dataAddr,
	output logic psvStall,
	output logic psvValid,
	output logic [15:0] psvRdData,
	input wire logic tblRd,
	input wire logic [15:0] tblPtr,
	output logic [23:0] tblRdData,
	input wire logic dualSrc,
	input wire logic [15:0] yAddrIn,
	output logic [15:0] yAddr,
	input wire logic [15:0] dstAddr,
	input wire logic bitRevEn,
	output logic [15:0] dstEa,
	input wire logic [3:0] accOp,
	input wire logic accSel,
	input wire logic [16:0] mulX,
	input wire logic [16:0] mulY,
	input wire logic [4:0] shiftAmt,
	input wire logic [39:0] loadVal,
	output logic [39:0] accumulator_a,
	output logic [39:0] accumulator_b,
	input wire logic [`N_TRAPS-1:0] trapPend,
	input wire logic [`N_IRQS-1:0] irqPend,
	input wire logic [3*`N_IRQS-1:0] irqPrio,
	output logic excReq,
	output logic [5:0] excVector,
	input wire logic excAck,
	output logic [15:0] excStackWord
);

	// ----------------------------------------------------------------------
	// state
	// ----------------------------------------------------------------------
	logic [22:0] pc_q, pc_d; // program counter
	logic [23:0] instr_q; // prefetched instruction
	logic [15:0] sp_q, sp_d; // stack pointer
	logic [15:0] wLow_q [4]; // registers zero to three, shadowed
	logic [15:0] wShadow_q [4]; // hidden copies
	logic [15:0] status_q, status_d; // status word
	logic [15:0] stShadow_q; // hidden flag copy
	logic [7:0] psvPage_q; // visibility page
	logic [7:0] tblPage_q; // table page
	logic [22:0] loopStart_q, loopEnd_q, loopStartSh_q, loopEndSh_q; // loop bounds
	logic [13:0] loopCount_q, loopCountSh_q; // loop count
	cpu_model_pkg::psvState_t psvState_q; // window sequencer
	logic [15:0] psvData_q; // window read data
	logic psvValid_q; // window data valid pulse
	logic [23:0] tblData_q; // table read data
	logic [39:0] acc_q [2]; // accumulators a and b
	logic [3:0] rdSrc_q; // which source the read returns
	logic [15:0] memRd; // memory read port

	// ----------------------------------------------------------------------
	// program counter and prefetch
	// ----------------------------------------------------------------------
	wire psvBusy = psvState_q == cpu_model_pkg::PSV_WAIT;
	// hold fetch while a window access owns the program port, else the window word is fetched
	wire fetchStall = pcHold | psvStall | psvBusy;
	assign pc_d = pcLoad ? {pcTarget[22:1], 1'b0} : pc_q + `PC_STEP;
	wire [23:0] psvProgAddr = {1'b0, psvPage_q, dataAddr[14:0]};
	assign progAddr = psvBusy ? psvProgAddr
		: tblRd ? {tblPage_q, tblPtr} : {1'b0, pc_q};

	// pc advances each cycle that fetch is not stalled and no table read owns the port; the fetched word is held for the next cycle
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pc_q <= '0;
			instr_q <= '0;
		end
		else if (!fetchStall && !tblRd)
		begin
			pc_q <= pc_d;
			instr_q <= progRdData;
		end
	end
	assign instrQ = instr_q;

	// ----------------------------------------------------------------------
	// working registers
	// ----------------------------------------------------------------------
	wire isSp = wrSel == `SP_IDX;
	wire isLow = wrSel <= `SHADOW_TOP;
	// a byte operation narrows the write to the low lane
	wire [1:0] laneEn = wrByteOp ? 2'b01 : wrByteEn;
	assign wrEn = |laneEn;
	wire [15:0] spWr = {laneEn[1] ? wrData[15:8] : sp_q[15:8],
		laneEn[0] ? wrData[7:0] : sp_q[7:0]};

	work_reg_mem #(.DEPTH(16), .WIDTH(16), .AW(4)) regMem (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.wrEn(wrEn && !isSp && !isLow),
		.wrAddr(wrSel),
		.byteEn(laneEn),
		.wrData(wrData),
		.rdAddr(rdSel),
		.rdData(memRd)
	);

	// hardware adjustment beats a software write in the same cycle
	assign sp_d = spPush ? sp_q + `SP_STEP
		: spPop ? sp_q - `SP_STEP
		: (wrEn && isSp) ? spWr : sp_q;

	// stack pointer and shadowed low registers
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sp_q <= `SP_RESET;
			for (int i = 0; i < 4; i++)
			begin
				wLow_q[i] <= '0;
				wShadow_q[i] <= '0;
			end
		end
		else
		begin
			sp_q <= {sp_d[15:1], 1'b0};
			for (int i = 0; i < 4; i++)
			begin
				if (shadowPush)
					wShadow_q[i] <= wLow_q[i];
				if (shadowPop)
					wLow_q[i] <= wShadow_q[i];
				else if (wrEn && wrSel == 4'(i))
				begin
					if (laneEn[0])
						wLow_q[i][7:0] <= wrData[7:0];
					if (laneEn[1])
						wLow_q[i][15:8] <= wrData[15:8];
				end
			end
		end
	end

	// read source follows the memory's one-cycle latency
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			rdSrc_q <= '0;
		else
			rdSrc_q <= rdSel;
	end
	wire [15:0] lowRd = wLow_q[rdSrc_q[1:0]];
	assign rdData = (rdSrc_q == `SP_IDX) ? sp_q
		: (rdSrc_q <= `SHADOW_TOP) ? lowRd : memRd;

	// ----------------------------------------------------------------------
	// status word, pages and loop registers
	// ----------------------------------------------------------------------
	wire [2:0] takenLevel; // level of the exception being taken
	// exception entry raises the level; shadow pop restores only the flags
	always_comb
	begin
		status_d = statusWrEn ? statusWrData : status_q;
		if (shadowPop)
			status_d = (status_d & ~`ST_SHADOW_MASK) | (stShadow_q & `ST_SHADOW_MASK);
		if (excAck)
			status_d[`ST_LEVEL_HI:`ST_LEVEL_LO] = takenLevel;
		status_d[`ST_LOOP] = loopStart ? 1'b1 : loopEnd ? 1'b0 : status_d[`ST_LOOP];
	end

	// control registers
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			status_q <= `STATUS_RESET;
			stShadow_q <= '0;
			psvPage_q <= `PAGE_RESET;
			tblPage_q <= `PAGE_RESET;
		end
		else
		begin
			status_q <= status_d;
			if (shadowPush)
				stShadow_q <= status_q & `ST_SHADOW_MASK;
			if (psvWrEn)
				psvPage_q <= psvWrData;
			if (tblPageWrEn)
				tblPage_q <= tblPageWrData;
		end
	end
	assign statusWord = status_q;

	// nested loops: push on start, pop on end
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			loopStart_q <= '0;
			loopEnd_q <= '0;
			loopCount_q <= '0;
			loopStartSh_q <= '0;
			loopEndSh_q <= '0;
			loopCountSh_q <= '0;
		end
		else if (loopStart)
		begin
			loopStartSh_q <= loopStart_q;
			loopEndSh_q <= loopEnd_q;
			loopCountSh_q <= loopCount_q;
			loopStart_q <= loopStartAddr;
			loopEnd_q <= loopEndAddr;
			loopCount_q <= loopCountIn;
		end
		else if (loopEnd)
		begin
			loopStart_q <= loopStartSh_q;
			loopEnd_q <= loopEndSh_q;
			loopCount_q <= loopCountSh_q;
		end
	end
	assign loopCount = loopCount_q;

	// ----------------------------------------------------------------------
	// data space: visibility window, table reads, address generators
	// ----------------------------------------------------------------------
	wire psvHit = dataRd && dataAddr[`PSV_BIT];
	// the stall is the extra cycle spent fetching the program word
	assign psvStall = psvHit && (psvState_q == cpu_model_pkg::PSV_IDLE);

	// two-state sequencer: request cycle, then capture cycle
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			psvState_q <= cpu_model_pkg::PSV_IDLE;
			psvData_q <= '0;
			psvValid_q <= 1'b0;
			tblData_q <= '0;
		end
		else
		begin
			psvValid_q <= psvBusy;
			unique case (psvState_q)
				cpu_model_pkg::PSV_IDLE:
					if (psvHit)
						psvState_q <= cpu_model_pkg::PSV_WAIT;
				cpu_model_pkg::PSV_WAIT:
				begin
					psvData_q <= progRdData[15:0];
					psvState_q <= cpu_model_pkg::PSV_IDLE;
				end
			endcase
			if (tblRd && !psvBusy)
				tblData_q <= progRdData;
		end
	end
	assign psvValid = psvValid_q;
	assign psvRdData = psvData_q;
	assign tblRdData = tblData_q;

	// y generator used only by dual-source instructions, fixed base
	assign yAddr = dualSrc ? (yAddrIn | `Y_BASE) : '0;
	// bit-reversed word index, applied only to the x destination
	logic [BR_BITS-1:0] brIdx;
	always_comb
	begin
		for (int i = 0; i < BR_BITS; i++)
			brIdx[i] = dstAddr[BR_BITS-i];
	end
	assign dstEa = bitRevEn ? {dstAddr[15:BR_BITS+1], brIdx, 1'b0} : dstAddr;

	// ----------------------------------------------------------------------
	// arithmetic: multiplier, shifter, saturating accumulators
	// ----------------------------------------------------------------------
	wire signed [33:0] product = $signed(mulX) * $signed(mulY);
	wire [39:0] acc = acc_q[accSel];
	// positive amount shifts right, negative shifts left
	wire [39:0] shifted = shiftAmt[4] ? (acc << (5'd0 - shiftAmt))
		: 40'($signed(acc) >>> shiftAmt);
	wire [40:0] sum = {acc[39], acc} + {{7{product[33]}}, product};
	wire sumOvf = sum[40] != sum[39];
	// clip to the extreme of the sign that was lost
	wire [39:0] satSum = sumOvf ? {sum[40], {39{~sum[40]}}} : sum[39:0];
	logic [39:0] accNext;
	always_comb
	begin
		unique case (accOp)
			cpu_model_pkg::ACC_CLR: accNext = '0;
			cpu_model_pkg::ACC_MAC: accNext = satSum;
			cpu_model_pkg::ACC_LOAD: accNext = shiftAmt == 5'h00 ? loadVal : shifted;
			default: accNext = acc;
		endcase
	end

	// only the selected accumulator changes
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			acc_q[0] <= '0;
			acc_q[1] <= '0;
		end
		else
			acc_q[accSel] <= accNext;
	end
	assign accumulator_a = acc_q[0];
	assign accumulator_b = acc_q[1];

	// ----------------------------------------------------------------------
	// exception priority
	// ----------------------------------------------------------------------
	logic [3:0] srcPrio [`N_VECTORS]; // per-vector effective priority
	genvar g;
	generate
		for (g = 0; g < `N_VECTORS; g++)
		begin : gPrio
			if (g < `N_TRAPS)
				assign srcPrio[g] = trapPend[g] ? `TRAP_PRIO_BASE + 4'(g) : 4'h0;
			else
				assign srcPrio[g] = irqPend[g-`N_TRAPS]
					? {1'b0, irqPrio[3*(g-`N_TRAPS) +: 3]} : 4'h0;
		end
	endgenerate

	// strictly greater keeps the lowest index among equals
	logic [3:0] bestPrio;
	logic [5:0] bestVec;
	always_comb
	begin
		bestPrio = 4'h0;
		bestVec = 6'h00;
		for (int i = 0; i < `N_VECTORS; i++)
			if (srcPrio[i] > bestPrio)
			begin
				bestPrio = srcPrio[i];
				bestVec = 6'(i);
			end
	end
	// a request must beat the current level; traps always do
	assign excReq = bestPrio > {1'b0, status_q[`ST_LEVEL_HI:`ST_LEVEL_LO]};
	assign excVector = bestVec;
	assign takenLevel = bestPrio[3] ? 3'h7 : bestPrio[2:0];
	assign excStackWord = {status_q[7:0], 1'b0, pc_q[22:16]};

	// ----------------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------------
	a_sp_reset_value: assert property (@(posedge ref_clk)
		$rose(rst_b) |-> sp_q == `SP_RESET) else $error("stack pointer reset value wrong");
	a_sp_align: assert property (@(posedge ref_clk) disable iff (!rst_b)
		sp_q[0] == 1'b0) else $error("stack pointer misaligned");
	a_sp_push_step: assert property (@(posedge ref_clk) disable iff (!rst_b)
		spPush |=> sp_q == $past(sp_q) + `SP_STEP) else $error("push did not step by two");
	a_pc_even: assert property (@(posedge ref_clk) disable iff (!rst_b)
		pc_q[0] == 1'b0) else $error("pc bit 0 set");
	a_byte_op_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wrByteOp && wrSel == 4'h0 && !shadowPop |=> wLow_q[0][15:8] == $past(wLow_q[0][15:8]))
		else $error("byte op changed high byte");
	a_psv_one_extra: assert property (@(posedge ref_clk) disable iff (!rst_b)
		psvStall |=> !psvStall ##1 psvValid) else $error("window access timing wrong");
	a_shadow_roundtrip: assert property (@(posedge ref_clk) disable iff (!rst_b)
		shadowPush ##1 (shadowPop && !shadowPush) |=> wLow_q[1] == $past(wLow_q[1], 2))
		else $error("shadow pop did not restore");
	a_trap_wins: assert property (@(posedge ref_clk) disable iff (!rst_b)
		|trapPend |-> excReq && excVector < 6'(`N_TRAPS)) else $error("trap lost to interrupt");
	a_loop_restore: assert property (@(posedge ref_clk) disable iff (!rst_b)
		loopStart ##1 (loopEnd && !loopStart) |=> loopCount == $past(loopCount, 2))
		else $error("loop end did not restore count");

endmodule // cpu_prog_model

/* dsp_cpu_programmer_model_tb.sv */
// self-checking bench for the programmer-visible core state
module dsp_cpu_programmer_model_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	// every input starts at a known value at time zero
	logic ref_clk = 1'b0, rst_b = 1'b0, pcLoad = 1'b0, pcHold = 1'b1, wrByteOp = 1'b0;
	logic spPush = 1'b0, spPop = 1'b0, shadowPush = 1'b0, shadowPop = 1'b0;
	logic statusWrEn = 1'b0, psvWrEn = 1'b0, tblPageWrEn = 1'b0, loopStart = 1'b0;
	logic loopEnd = 1'b0, dataRd = 1'b0, tblRd = 1'b0, dualSrc = 1'b0, bitRevEn = 1'b0;
	logic accSel = 1'b0, excAck = 1'b0;
	logic [22:0] pcTarget = '0, loopStartAddr = '0, loopEndAddr = '0;
	logic [3:0] wrSel = '0, rdSel = '0, accOp = 4'h1;
	logic [15:0] wrData = '0, statusWrData = '0, dataAddr = '0, tblPtr = '0;
	logic [15:0] yAddrIn = '0, dstAddr = '0;
	logic [1:0] wrByteEn = '0;
	logic [7:0] psvWrData = '0, tblPageWrData = '0, trapPend = '0;
	logic [13:0] loopCountIn = '0;
	logic [16:0] mulX = '0, mulY = '0;
	logic [4:0] shiftAmt = '0;
	logic [39:0] loadVal = '0;
	logic [53:0] irqPend = '0;
	logic [161:0] irqPrio = '0;
	// outputs of the design and the memory
	logic [23:0] progRdData, progAddr, instrQ, tblRdData;
	logic [15:0] rdData, statusWord, psvRdData, yAddr, dstEa, excStackWord;
	logic [13:0] loopCount;
	logic [39:0] accumulator_a, accumulator_b;
	logic [5:0] excVector;
	logic wrEn, psvStall, psvValid, excReq;
	// bench model of the register array and its shadows
	int regs [16];
	int shadowRegs [4];
	int miscompares = 0;
	int testsRun = 0;

	// ----------------------------------------
	// design and far side
	// ----------------------------------------
	cpu_prog_model uut (.ref_clk, .rst_b, .pcLoad, .pcTarget, .pcHold, .progRdData, .progAddr,
		.instrQ, .wrEn, .wrSel, .wrData, .wrByteEn, .wrByteOp, .rdSel, .rdData, .spPush,
		.spPop, .shadowPush, .shadowPop, .statusWrEn, .statusWrData, .statusWord, .psvWrEn,
		.psvWrData, .tblPageWrEn, .tblPageWrData, .loopStart, .loopEnd, .loopStartAddr,
		.loopEndAddr, .loopCountIn, .loopCount, .dataRd, .dataAddr, .psvStall, .psvValid,
		.psvRdData, .tblRd, .tblPtr, .tblRdData, .dualSrc, .yAddrIn, .yAddr, .dstAddr,
		.bitRevEn, .dstEa, .accOp, .accSel, .mulX, .mulY, .shiftAmt, .loadVal, .accumulator_a, .accumulator_b,
		.trapPend, .irqPend, .irqPrio, .excReq, .excVector, .excAck, .excStackWord);
	prog_mem_model mem (.progAddr, .progRdData);

	// ----------------------------------------
	// clock, watchdog and helpers
	// ----------------------------------------
	// 100 MHz free-running clock
	initial
	begin
		forever #5 ref_clk = ~ref_clk;
	end
	// the whole run needs well under a thousand cycles
	initial
	begin
		#300000;
		miscompares++;
		endSim();
	end
	// same pattern as the memory model, written out independently
	function automatic logic [23:0] memWord(input logic [23:0] a);
		return {a[7:0] ^ 8'h5a, a[23:8]};
	endfunction
	// one compare for every result value
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		testsRun++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// register write through the lanes; the model keeps bit 0 of the stack clear
	task automatic wr(input int s, input logic [15:0] d, input logic [1:0] be, input logic bo);
		@(posedge ref_clk);
		wrSel <= 4'(s);
		wrData <= d;
		wrByteEn <= be;
		wrByteOp <= bo;
		@(posedge ref_clk);
		wrByteEn <= 2'b00;
		wrByteOp <= 1'b0;
		if (bo)
			be = 2'b01;
		if (be[0])
			regs[s][7:0] = d[7:0];
		if (be[1])
			regs[s][15:8] = d[15:8];
		if (s == 15)
			regs[s][0] = 1'b0;
	endtask
	// registered read port: select, one edge, then look
	task automatic rdChk(input int s);
		@(posedge ref_clk);
		rdSel <= 4'(s);
		@(posedge ref_clk);
		#1;
		chk(40'(rdData), 40'(regs[s]));
	endtask
	// status word write, one cycle
	task automatic stw(input logic [15:0] d);
		@(posedge ref_clk);
		statusWrEn <= 1'b1;
		statusWrData <= d;
		@(posedge ref_clk);
		statusWrEn <= 1'b0;
	endtask
	// counts and verdict; every path of the run ends here
	task automatic endSim();
		$display("comparisons %0d mismatches %0d", testsRun, miscompares);
		if (miscompares == 0 && testsRun > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(32'hcd8b168d));
		regs[15] = 32'h0800;
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		rdChk(15);
		chk(40'(statusWord), 40'h0);
		$display("reset test done");
		// random words, then lane and byte-operation writes
		for (int i = 0; i < 15; i++)
			wr(i, 16'($urandom), 2'b11, 1'b0);
		for (int i = 0; i < 16; i++)
			rdChk(i);
		wr(3, 16'hffff, 2'b11, 1'b1);
		wr(4, 16'habcd, 2'b10, 1'b0);
		rdChk(3);
		rdChk(4);
		wr(0, 16'h5a5a, 2'b11, 1'b1);
		rdChk(0);
		// odd stack address, then a hardware push
		wr(15, 16'h1235, 2'b11, 1'b0);
		rdChk(15);
		@(posedge ref_clk);
		spPush <= 1'b1;
		@(posedge ref_clk);
		spPush <= 1'b0;
		regs[15] += 2;
		rdChk(15);
		$display("register test done");
		// shadow: only the five flags travel with the low four registers
		stw(16'h010f);
		@(posedge ref_clk);
		shadowPush <= 1'b1;
		@(posedge ref_clk);
		shadowPush <= 1'b0;
		for (int i = 0; i < 4; i++)
			shadowRegs[i] = regs[i];
		stw(16'h00f0);
		for (int i = 0; i < 4; i++)
			wr(i, 16'($urandom), 2'b11, 1'b0);
		@(posedge ref_clk);
		shadowPop <= 1'b1;
		@(posedge ref_clk);
		shadowPop <= 1'b0;
		for (int i = 0; i < 4; i++)
			regs[i] = shadowRegs[i];
		#1;
		chk(40'(statusWord), 40'h01ff);
		for (int i = 0; i < 4; i++)
			rdChk(i);
		// push then pop on the next edge leaves the registers as they were
		@(posedge ref_clk);
		shadowPush <= 1'b1;
		@(posedge ref_clk);
		shadowPush <= 1'b0;
		shadowPop <= 1'b1;
		@(posedge ref_clk);
		shadowPop <= 1'b0;
		rdChk(1);
		$display("shadow test done");
		// odd target lands even, then held
		@(posedge ref_clk);
		pcLoad <= 1'b1;
		pcHold <= 1'b0;
		pcTarget <= 23'h7a0013;
		@(posedge ref_clk);
		pcLoad <= 1'b0;
		#1;
		chk(40'(progAddr), 40'h7a0012);
		// one free cycle prefetches the word at the loaded address
		@(posedge ref_clk);
		pcHold <= 1'b1;
		#1;
		chk(40'(instrQ), 40'(memWord(24'h7a0012)));
		// table read of a full word, then a window read
		@(posedge ref_clk);
		tblPageWrEn <= 1'b1;
		tblPageWrData <= 8'h3c;
		psvWrEn <= 1'b1;
		psvWrData <= 8'h12;
		@(posedge ref_clk);
		tblPageWrEn <= 1'b0;
		psvWrEn <= 1'b0;
		tblRd <= 1'b1;
		tblPtr <= 16'h1235;
		#1;
		chk(40'(progAddr), 40'h3c1235);
		@(posedge ref_clk);
		tblRd <= 1'b0;
		dataRd <= 1'b1;
		dataAddr <= 16'h8004;
		#1;
		chk(40'(tblRdData), 40'(memWord(24'h3c1235)));
		chk(40'(psvStall), 40'h1);
		@(posedge ref_clk);
		dataRd <= 1'b0;
		#1;
		chk(40'(progAddr), 40'h090004);
		@(posedge ref_clk);
		#1;
		chk({psvValid, psvRdData}, {1'b1, 16'(memWord(24'h090004))});
		$display("program access test done");
		// second generator and bit reversal
		@(posedge ref_clk);
		dualSrc <= 1'b1;
		yAddrIn <= 16'h0010;
		bitRevEn <= 1'b1;
		dstAddr <= 16'h0102;
		#1;
		chk(40'(yAddr), 40'h0810);
		chk(40'(dstEa), 40'h0110);
		// clear then one signed multiply-accumulate
		@(posedge ref_clk);
		accOp <= 4'h2;
		@(posedge ref_clk);
		accOp <= 4'h4;
		mulX <= 17'h00003;
		mulY <= 17'h1fffe;
		@(posedge ref_clk);
		accOp <= 4'h1;
		#1;
		chk(accumulator_a, -40'sd6);
		// load b, shift it 16 left, then 15 right
		@(posedge ref_clk);
		accSel <= 1'b1;
		accOp <= 4'h8;
		loadVal <= 40'h0000001234;
		@(posedge ref_clk);
		shiftAmt <= 5'h10;
		@(posedge ref_clk);
		shiftAmt <= 5'h0f;
		#1;
		chk(accumulator_b, 40'h0012340000);
		@(posedge ref_clk);
		accOp <= 4'h1;
		shiftAmt <= 5'h00;
		#1;
		chk(accumulator_b, 40'h0000002468);
		// nested loop start, then one end restores the outer count
		@(posedge ref_clk);
		loopStart <= 1'b1;
		loopCountIn <= 14'h0005;
		@(posedge ref_clk);
		loopCountIn <= 14'h0009;
		@(posedge ref_clk);
		loopStart <= 1'b0;
		loopEnd <= 1'b1;
		#1;
		chk({statusWord[9], 26'h0, loopCount}, {1'b1, 26'h0, 14'h0009});
		@(posedge ref_clk);
		loopEnd <= 1'b0;
		#1;
		chk(40'(loopCount), 40'h0005);
		$display("datapath test done");
		// priorities: equal ties, top interrupt, every trap
		stw(16'h0000);
		@(posedge ref_clk);
		irqPend <= 54'h1 << 53 | 54'h408;
		irqPrio <= 162'h7 << 159 | 162'h5 << 30 | 162'h5 << 9;
		#1;
		chk({excReq, excVector}, {1'b1, 6'd61});
		@(posedge ref_clk);
		irqPend[53] <= 1'b0;
		#1;
		chk({excReq, excVector}, {1'b1, 6'd11});
		for (int i = 0; i < 8; i++)
		begin
			@(posedge ref_clk);
			trapPend <= 8'h1 << i;
			#1;
			chk(40'(excVector), 40'(i));
		end
		chk(40'(excStackWord), 40'h007a);
		@(posedge ref_clk);
		excAck <= 1'b1;
		@(posedge ref_clk);
		excAck <= 1'b0;
		trapPend <= 8'h00;
		#1;
		chk({excReq, 36'h0, statusWord[7:5]}, {1'b0, 36'h0, 3'h7});
		$display("exception test done");
		endSim();
	end
endmodule // dsp_cpu_programmer_model_tb

/* prog_mem_model.sv */
// combinational program memory standing on the far side of the core
module prog_mem_model (
	input wire logic [23:0] progAddr,
	output logic [23:0] progRdData
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// read path
	// ----------------------------------------
	// answers in the same cycle; the folded pattern makes every data bit
	// depend on a different address bit, so a wrong page or lane shows up
	assign progRdData = {progAddr[7:0] ^ 8'h5a, progAddr[23:8]};
endmodule // prog_mem_model

/* work_reg_mem.sv */
// working register storage with byte-lane writes and a registered read port
module work_reg_mem #(
	parameter int DEPTH = 16,
	parameter int WIDTH = 16,
	parameter int AW = 4
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [1:0] byteEn,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic [AW-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);

	// ----------------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------------
	logic [WIDTH-1:0] mem [DEPTH]; // no reset: contents undefined until written
	logic [WIDTH-1:0] rdData_q; // read data register

	// per-lane write, upper lane only when its enable is set
	always_ff @(posedge ref_clk)
	begin
		if (wrEn && byteEn[0])
			mem[wrAddr][7:0] <= wrData[7:0];
		if (wrEn && byteEn[1])
			mem[wrAddr][WIDTH-1:8] <= wrData[WIDTH-1:8];
	end

	// registered read, one cycle after the address
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			rdData_q <= '0;
		else
			rdData_q <= mem[rdAddr];
	end

	assign rdData = rdData_q;

endmodule // work_reg_mem
